// ### rtl/lssc_top.v
// Purpose: serial command interpreter of a linear sensor array
// Assumes: I_CORE_CLK is the serial clock; pixel data arrives ready
// Notes: analog side is reached through plain ports
`timescale 1ns/10ps
`include "lssc_defs.vh"
module lssc_top (
	// clock, reset, enable
	input wire I_CORE_CLK,
	input wire I_RESETN,
	input wire I_CLK_EN,
	// serial link
	input wire I_SERIAL_COMMAND_INPUT,
	output wire O_SERIAL_RESULT_OUTPUT,
	// pixel data source
	input wire [7:0] I_PIXEL_DATA,
	output wire [6:0] O_PIXEL_INDEX,
	// analog control
	output wire O_SLEEP_SELECT_BIT,
	output wire O_INTEGRATE,
	output wire O_PIXEL_RESET,
	output wire O_SAMPLE_PULSE,
	output wire O_READOUT_ACTIVE,
	output wire [7:0] O_MODE
);
	reg sin_q;
	reg armed_q, rx_act_q;
	reg [3:0] rx_cnt_q, zero_cnt_q;
	reg [7:0] rx_sh_q;
	reg wr_pend_q;
	reg [4:0] wr_addr_q;
	reg [1:0] rst_cnt_q;
	reg [7:0] regs_q [0:6];
	reg rd_wait_q;
	reg [2:0] rd_cnt_q;
	reg [7:0] rd_val_q;
	reg pix_act_q, pix_go_q;
	reg [5:0] pix_cnt_q;
	reg [6:0] pix_idx_q;
	reg integ_q, prst_q, samp_q;
	reg [4:0] prst_cnt_q;
	reg tx_busy_q;
	reg [3:0] tx_cnt_q;
	reg [9:0] tx_sh_q;
	reg sout_q;
	reg [7:0] rval;
	integer i;
	wire [7:0] cmd = rx_sh_q;
	wire byte_ok = rx_act_q && rx_cnt_q == `LSSC_FRAME_LAST && sin_q;
	wire brk = zero_cnt_q == `LSSC_BREAK_ZEROS;
	wire is_cmd = byte_ok && !wr_pend_q;
	wire c_rst = is_cmd && cmd == `LSSC_CMD_RESET;
	wire c_abort = c_rst || (is_cmd && cmd == `LSSC_CMD_ABORT);
	wire c_sample = is_cmd && (cmd == `LSSC_CMD_SAMPLE ||
		cmd == `LSSC_CMD_SAMP_READ || cmd == `LSSC_CMD_SAMP_RESTART);
	wire c_read = is_cmd && (cmd == `LSSC_CMD_READOUT ||
		cmd == `LSSC_CMD_SAMP_READ || cmd == `LSSC_CMD_SAMP_RESTART);
	wire c_start = is_cmd && (cmd == `LSSC_CMD_START ||
		cmd == `LSSC_CMD_SAMP_RESTART);
	wire c_wr = is_cmd && (cmd & `LSSC_OP_MASK) == `LSSC_OP_WRITE;
	wire c_rd = is_cmd && (cmd & `LSSC_OP_MASK) == `LSSC_OP_READ;
	wire rd_fire = rd_wait_q && rd_cnt_q == 3'h1;
	wire pix_fire = pix_go_q && !tx_busy_q && !rd_fire && !rd_wait_q;

	// map a 5-bit address to storage, unmapped reads give zero
	always @* begin
		rval = 8'h00;
		if (cmd[4:0] == `LSSC_ADDR_MODE) begin
			rval = regs_q[`LSSC_IDX_MODE];
		end else if (cmd[4:0] <= `LSSC_ADDR_LAST_ZONE) begin
			rval = regs_q[cmd[2:0]];
			if (cmd[0])
				rval = regs_q[cmd[2:0]] & `LSSC_GAIN_MASK;
		end
	end

	always @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			sin_q <= 1'b1;
			armed_q <= 1'b0;
			rx_act_q <= 1'b0;
			rx_cnt_q <= 4'h0;
			zero_cnt_q <= 4'h0;
			rx_sh_q <= 8'h00;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 5'h00;
			rst_cnt_q <= 2'h0;
			for (i = 0; i < 7; i = i + 1)
				regs_q[i] <= `LSSC_MODE_RESET;
			rd_wait_q <= 1'b0;
			rd_cnt_q <= 3'h0;
			rd_val_q <= 8'h00;
			pix_act_q <= 1'b0;
			pix_go_q <= 1'b0;
			pix_cnt_q <= 6'h00;
			pix_idx_q <= 7'h00;
			integ_q <= 1'b0;
			prst_q <= 1'b0;
			samp_q <= 1'b0;
			prst_cnt_q <= 5'h00;
			tx_busy_q <= 1'b0;
			tx_cnt_q <= 4'h0;
			tx_sh_q <= 10'h3ff;
		end else if (I_CLK_EN) begin
			// line is launched by this same clock, so no synchroniser;
			// an agree filter would swallow one-clock data bits
			sin_q <= I_SERIAL_COMMAND_INPUT;
			// break detector counts consecutive low bits
			if (sin_q)
				zero_cnt_q <= 4'h0;
			else if (!brk)
				zero_cnt_q <= zero_cnt_q + 4'h1;
			// a high line arms the receiver so a start is seen cleanly
			if (sin_q && !rx_act_q)
				armed_q <= 1'b1;
			// receiver frame: start, eight data lsb first, stop
			if (brk) begin
				rx_act_q <= 1'b0;
				armed_q <= 1'b0;
			end else if (rx_act_q) begin
				if (rx_cnt_q == `LSSC_FRAME_LAST)
					rx_act_q <= 1'b0;
				else
					rx_cnt_q <= rx_cnt_q + 4'h1;
				if (rx_cnt_q != `LSSC_FRAME_LAST)
					rx_sh_q <= {sin_q, rx_sh_q[7:1]};
			end else if (armed_q && !sin_q) begin
				rx_act_q <= 1'b1;
				rx_cnt_q <= 4'h1;
			end
			// interpreter; break and reset both clear it
			if (brk || c_rst)
				wr_pend_q <= 1'b0;
			else if (byte_ok && wr_pend_q) begin
				wr_pend_q <= 1'b0;
				if (wr_addr_q == `LSSC_ADDR_MODE)
					regs_q[`LSSC_IDX_MODE] <= cmd;
				else if (wr_addr_q <= `LSSC_ADDR_LAST_ZONE)
					regs_q[wr_addr_q[2:0]] <= cmd;
			end else if (c_wr) begin
				wr_pend_q <= 1'b1;
				wr_addr_q <= cmd[4:0];
			end
			// three resets in a row count as a full initialisation
			if (brk)
				rst_cnt_q <= `LSSC_RESET_REPEAT;
			else if (c_rst && rst_cnt_q != `LSSC_RESET_REPEAT)
				rst_cnt_q <= rst_cnt_q + 2'h1;
			else if (is_cmd && !c_rst)
				rst_cnt_q <= 2'h0;
			// register read waits four clocks after its stop bit
			if (brk || c_rst)
				rd_wait_q <= 1'b0;
			else if (c_rd) begin
				rd_wait_q <= 1'b1;
				rd_cnt_q <= `LSSC_READ_DELAY;
				rd_val_q <= rval;
			end else if (rd_wait_q) begin
				rd_cnt_q <= rd_cnt_q - 3'h1;
				if (rd_fire)
					rd_wait_q <= 1'b0;
			end
			// pixel read-out: initial delay then bytes with one idle bit between
			samp_q <= c_sample;
			if (brk || c_abort) begin
				pix_act_q <= 1'b0;
				pix_go_q <= 1'b0;
			end else if (c_read) begin
				pix_act_q <= 1'b1;
				pix_go_q <= 1'b0;
				pix_cnt_q <= `LSSC_PIXEL_DELAY;
				pix_idx_q <= 7'h00;
			end else if (pix_act_q && !pix_go_q) begin
				pix_cnt_q <= pix_cnt_q - 6'h01;
				if (pix_cnt_q == 6'h01)
					pix_go_q <= 1'b1;
			end else if (pix_fire) begin
				// index rests on the last pixel, never past it
				if (pix_idx_q == `LSSC_PIXEL_LAST) begin
					pix_act_q <= 1'b0;
					pix_go_q <= 1'b0;
				end else
					pix_idx_q <= pix_idx_q + 7'h01;
			end
			// integration control, sleep does not block any of it
			if (brk || c_abort) begin
				integ_q <= 1'b0;
				prst_q <= 1'b0;
			end else if (c_start) begin
				integ_q <= 1'b0;
				prst_q <= 1'b1;
				prst_cnt_q <= `LSSC_PRST_CLOCKS;
			end else if (prst_q) begin
				prst_cnt_q <= prst_cnt_q - 5'h01;
				if (prst_cnt_q == 5'h01) begin
					prst_q <= 1'b0;
					integ_q <= 1'b1;
				end
			end else if (c_sample)
				integ_q <= 1'b0;
			// transmitter; register read beats a pending pixel byte
			if (brk || c_rst)
				tx_busy_q <= 1'b0;
			else if (rd_fire) begin
				tx_busy_q <= 1'b1;
				tx_cnt_q <= 4'h0;
				tx_sh_q <= {1'b1, rd_val_q, 1'b0};
			end else if (pix_fire) begin
				tx_busy_q <= 1'b1;
				tx_cnt_q <= 4'h0;
				tx_sh_q <= {1'b1, I_PIXEL_DATA, 1'b0};
			end else if (tx_busy_q) begin
				tx_sh_q <= {1'b1, tx_sh_q[9:1]};
				tx_cnt_q <= tx_cnt_q + 4'h1;
				if (tx_cnt_q == `LSSC_FRAME_LAST)
					tx_busy_q <= 1'b0;
			end
		end
	end

	// output changes on the falling edge, half a clock of hold
	always @(negedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN)
			sout_q <= 1'b1;
		else if (I_CLK_EN)
			sout_q <= tx_busy_q ? tx_sh_q[0] : 1'b1;
	end

	assign O_SERIAL_RESULT_OUTPUT = sout_q;
	assign O_PIXEL_INDEX = pix_idx_q;
	assign O_MODE = regs_q[`LSSC_IDX_MODE];
	// logic keeps running in sleep; only analog side powers down
	assign O_SLEEP_SELECT_BIT = O_MODE[`LSSC_SLEEP_BIT];
	assign O_INTEGRATE = integ_q;
	assign O_PIXEL_RESET = prst_q;
	assign O_SAMPLE_PULSE = samp_q;
	assign O_READOUT_ACTIVE = pix_act_q;
endmodule // lssc_top

// ### rtl/lssc_defs.vh
// Purpose: constants for the serial command interpreter
// Assumes: one serial clock drives all logic
// Notes: included by lssc_top.v
//
// Functional notes
// - write is command 010+addr then data byte
// - read is command 011+addr, returns stored value; odd zone addresses 1, 3 and 5 return only the low five bits
// - read data shifts out least bit first
// - four clocks wait before read data starts
// - break or three resets initialise control logic
// - output defined thirty clocks after reset commands
// - mode 0x10 sleeps, 0x00 restores normal
// - sleep leaves command logic fully working
// - start command releases integrators from reset
// - sample 0x10, read-out 0x02 act on arrival
// - start accepted anytime after a sample
// - 0x12 sample+read, 0x16 sample+read+start
// - start waits 22 clocks of pixel reset
// - link keeps working during pixel reset
// - byte framed start low, LSB first, stop high
// - mode bit 4 selects sleep
`ifndef LSSC_DEFS_VH
`define LSSC_DEFS_VH
`define LSSC_OP_MASK 8'he0
`define LSSC_OP_WRITE 8'h40
`define LSSC_OP_READ 8'h60
`define LSSC_CMD_RESET 8'h1b
`define LSSC_CMD_START 8'h08
`define LSSC_CMD_SAMPLE 8'h10
`define LSSC_CMD_READOUT 8'h02
`define LSSC_CMD_ABORT 8'h19
`define LSSC_CMD_SAMP_READ 8'h12
`define LSSC_CMD_SAMP_RESTART 8'h16
`define LSSC_ADDR_MODE 5'h1f
`define LSSC_ADDR_LAST_ZONE 5'h05
`define LSSC_IDX_MODE 3'h6
`define LSSC_MODE_RESET 8'h00
`define LSSC_SLEEP_BIT 4
`define LSSC_GAIN_MASK 8'h1f
`define LSSC_BREAK_ZEROS 4'ha
`define LSSC_RESET_REPEAT 2'h3
`define LSSC_FRAME_LAST 4'h9
`define LSSC_READ_DELAY 3'h4
`define LSSC_PIXEL_DELAY 6'h2c
`define LSSC_PRST_CLOCKS 5'h16
`define LSSC_PIXEL_LAST 7'h65
`endif

// ### sim/lssc_checker.sv
// Purpose: assertions on lssc_top ports
// Assumes: checks pause while I_CLK_EN is low
// Notes: bound below the module
`timescale 1ns/10ps
module lssc_checker (
	// clock, reset, enable
	input wire I_CORE_CLK,
	input wire I_RESETN,
	input wire I_CLK_EN,
	// outputs
	input wire O_SERIAL_RESULT_OUTPUT,
	input wire [6:0] O_PIXEL_INDEX,
	input wire O_SLEEP_SELECT_BIT,
	input wire O_INTEGRATE,
	input wire O_PIXEL_RESET,
	input wire O_SAMPLE_PULSE,
	input wire [7:0] O_MODE
);
	default clocking @(posedge I_CORE_CLK); endclocking
	// a frozen block stretches every count, so freeze aborts attempts
	default disable iff (!I_RESETN || !I_CLK_EN);
	// bit position in an outgoing frame, 0 = idle
	reg [3:0] bit_q;
	always @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN)
			bit_q <= 4'h0;
		else if (!I_CLK_EN)
			bit_q <= bit_q;
		else if (bit_q != 4'h0)
			bit_q <= (bit_q == 4'h9) ? 4'h0 : bit_q + 4'h1;
		else if (!O_SERIAL_RESULT_OUTPUT)
			bit_q <= 4'h1;
	end
	a_frame_stop: assert property (bit_q == 4'h9 |-> O_SERIAL_RESULT_OUTPUT)
		else $error("stop bit low");
	a_sleep_mirror: assert property (O_SLEEP_SELECT_BIT == O_MODE[4])
		else $error("sleep bit differs from mode");
	a_prst_length: assert property ($rose(O_PIXEL_RESET) |-> ##21
		O_PIXEL_RESET ##1 (!O_PIXEL_RESET && O_INTEGRATE))
		else $error("pixel reset not 22 clocks");
	a_prst_excl: assert property (O_PIXEL_RESET |-> !O_INTEGRATE)
		else $error("integrating in pixel reset");
	a_sample_pulse: assert property (O_SAMPLE_PULSE |=> !O_SAMPLE_PULSE)
		else $error("sample pulse too long");
	a_sample_stop: assert property (O_SAMPLE_PULSE |=> !O_INTEGRATE)
		else $error("sample left integration on");
	a_index_step: assert property (($changed(O_PIXEL_INDEX) &&
		O_PIXEL_INDEX != 7'h00) |-> O_PIXEL_INDEX == $past(O_PIXEL_INDEX) + 7'h01)
		else $error("pixel index skipped");
	a_index_range: assert property (O_PIXEL_INDEX <= 7'h65)
		else $error("pixel index past last");
endmodule // lssc_checker
bind lssc_top lssc_checker u_lssc_checker (.I_CORE_CLK(I_CORE_CLK),
	.I_RESETN(I_RESETN), .I_CLK_EN(I_CLK_EN),
	.O_SERIAL_RESULT_OUTPUT(O_SERIAL_RESULT_OUTPUT),
	.O_PIXEL_INDEX(O_PIXEL_INDEX), .O_SLEEP_SELECT_BIT(O_SLEEP_SELECT_BIT),
	.O_INTEGRATE(O_INTEGRATE), .O_PIXEL_RESET(O_PIXEL_RESET),
	.O_SAMPLE_PULSE(O_SAMPLE_PULSE), .O_MODE(O_MODE));

// ### sim/lssc_host.sv
// Purpose: host model driving the serial command line
// Assumes: bench calls its tasks
// Notes: line changes 5 ns after a rising edge
`timescale 1ns/10ps
module lssc_host (
	// clock
	input wire i_clk,
	// serial line
	output reg o_sdi
);
	initial o_sdi = 1'b1;
	task idle(input integer n);
		repeat (n) @(posedge i_clk);
	endtask
	task drive(input logic b);
		@(posedge i_clk) #5 o_sdi = b;
	endtask
	task send(input logic [7:0] b);
		integer i;
		drive(1'b0);
		for (i = 0; i < 8; i++) drive(b[i]);
		drive(1'b1);
		@(posedge i_clk);
	endtask
	// break: longer than ten zeros, then re-arm high
	task brk;
		repeat (12) drive(1'b0);
		drive(1'b1);
	endtask
	task cmd(input logic [7:0] b);
		send(b);
		idle(8);
	endtask
endmodule // lssc_host

// ### sim/lssc_top_tb_top.sv
// Purpose: self-checking bench for lssc_top
// Assumes: clock enable high except one freeze test
// Notes: pixel byte is index plus 0x30
`timescale 1ns/10ps
module lssc_top_tb_top;
	reg clk = 1'b0, rstn = 1'b0, smp_seen = 1'b0;
	reg clk_en = 1'b1;
	reg [7:0] pix = 8'h00, rx;
	wire sdi, sdo, sleep_select_bit, integ, prst, smp, ract;
	wire [6:0] idx;
	wire [7:0] mode;
	integer mismatches = 0, check_count = 0, cyc = 0, k, gap;
	logic [7:0] ta [4] = '{8'h00, 8'h01, 8'h1f, 8'h07};
	logic [7:0] td [4] = '{8'ha5, 8'hff, 8'h10, 8'h5a};
	logic [7:0] te [4] = '{8'ha5, 8'h1f, 8'h10, 8'h00};
	lssc_host u_lssc_host (.i_clk(clk), .o_sdi(sdi));
	lssc_top u_lssc_top (.I_CORE_CLK(clk), .I_RESETN(rstn), .I_CLK_EN(clk_en),
		.I_SERIAL_COMMAND_INPUT(sdi), .O_SERIAL_RESULT_OUTPUT(sdo),
		.I_PIXEL_DATA(pix), .O_PIXEL_INDEX(idx), .O_SLEEP_SELECT_BIT(sleep_select_bit),
		.O_INTEGRATE(integ), .O_PIXEL_RESET(prst), .O_SAMPLE_PULSE(smp),
		.O_READOUT_ACTIVE(ract), .O_MODE(mode));
	always #50 clk = ~clk;
	always @(posedge clk) #5 pix <= {1'b0, idx} + 8'h30;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (smp === 1'b1)
			smp_seen <= 1'b1;
		// two 1 ms settling waits plus three read-outs
		if (cyc == 40000) begin
			mismatches = mismatches + 1;
			complete_run;
		end
	end
	task check(input logic [7:0] seen, input logic [7:0] exp);
		check_count = check_count + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task get_byte;
		integer n;
		n = 0;
		@(posedge clk);
		while (sdo !== 1'b0 && n < 200) begin
			n = n + 1;
			@(posedge clk);
		end
		gap = n;
		for (n = 0; n < 8; n++) begin
			@(posedge clk);
			rx[n] = sdo;
		end
		@(posedge clk);
		check({7'h00, sdo}, 8'h01);
	endtask
	task rd(input logic [4:0] a, input logic [7:0] exp);
		u_lssc_host.send({3'b011, a});
		get_byte;
		// four quiet clocks after the stop, start seen on the fifth edge
		check(gap[7:0], 8'h05);
		check(rx, exp);
		u_lssc_host.idle(5);
	endtask
	task wr(input logic [4:0] a, input logic [7:0] d);
		u_lssc_host.send({3'b010, a});
		u_lssc_host.cmd(d);
	endtask
	task readout;
		for (k = 0; k < 102; k++) begin
			get_byte;
			check(rx, k[7:0] + 8'h30);
		end
	endtask
	task wait_int;
		k = 0;
		while (integ !== 1'b1 && k < 60) begin
			k = k + 1;
			@(posedge clk);
		end
	endtask
	task complete_run;
		$display("mismatches %0d checks %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		#5 rstn = 1'b1;
		u_lssc_host.idle(10);
		u_lssc_host.brk;
		u_lssc_host.idle(30);
		check({7'h00, sdo}, 8'h01);
		u_lssc_host.idle(10000);
		for (k = 0; k < 4; k++) wr(ta[k][4:0], td[k]);
		for (k = 0; k < 4; k++) rd(ta[k][4:0], te[k]);
		check({7'h00, sleep_select_bit}, 8'h01);
		u_lssc_host.cmd(8'h08);
		wr(5'h02, 8'h3c);
		wait_int;
		check({7'h00, integ}, 8'h01);
		rd(5'h02, 8'h3c);
		smp_seen = 1'b0;
		u_lssc_host.cmd(8'h10);
		check({6'h00, smp_seen, integ}, 8'h02);
		u_lssc_host.cmd(8'h02);
		check({7'h00, ract}, 8'h01);
		readout;
		check({7'h00, ract}, 8'h00);
		wr(5'h1f, 8'h00);
		check({sleep_select_bit, mode[6:0]}, 8'h00);
		u_lssc_host.idle(10000);
		smp_seen = 1'b0;
		u_lssc_host.send(8'h16);
		readout;
		check({6'h00, smp_seen, integ}, 8'h03);
		u_lssc_host.send(8'h12);
		readout;
		check({7'h00, integ}, 8'h00);
		u_lssc_host.cmd(8'h08);
		// freeze mid pixel reset: the count must not run on
		#5 clk_en = 1'b0;
		repeat (20) @(posedge clk);
		check({6'h00, prst, integ}, 8'h02);
		#5 clk_en = 1'b1;
		wait_int;
		check({7'h00, integ}, 8'h01);
		repeat (3) u_lssc_host.cmd(8'h1b);
		check({6'h00, prst, integ}, 8'h00);
		complete_run;
	end
endmodule // lssc_top_tb_top
